// ==== design/utc_regs.vh ====
`ifndef UTC_REGS_VH
`define UTC_REGS_VH
// special function register address of the transceiver control register
`define UTC_SFR_ADDR        8'hD7
`define UTC_RESET_VALUE     8'h00
// field positions in the transceiver control register
`define UTC_BIT_PULLUP_EN   7
`define UTC_BIT_PHY_EN      6
`define UTC_BIT_SPEED       5
`define UTC_BIT_TEST_HI     4
`define UTC_BIT_TEST_LO     3
`define UTC_BIT_DIFF_RX     2
`define UTC_BIT_DPLUS       1
`define UTC_BIT_DMINUS      0
`define UTC_WRITE_MASK      8'hF8
// transceiver test modes
`define UTC_TEST_NORMAL     2'h0
`define UTC_TEST_DIFF_ONE   2'h1
`define UTC_TEST_DIFF_ZERO  2'h2
`define UTC_TEST_SE_ZERO    2'h3
// endpoint addressing
`define UTC_NUM_PIPES       8
`define UTC_EP_CONTROL      2'h0
`define UTC_EP_IN_FLAG      8'h80
`define UTC_EP_NUM_MASK     8'h0F
`define UTC_EP_LAST         4'h3
`endif

// ==== design/utc_ep_decode.v ====
`timescale 1ns/10ps
module utc_ep_decode (
    // request
    input  wire [7:0] ep_addr,
    // result
    output wire       ep_hit,
    output wire [2:0] ep_pipe
);
`include "utc_regs.vh"
    wire [3:0] num;
    wire       dir_in;
    assign num    = ep_addr[3:0];
    assign dir_in = (ep_addr & `UTC_EP_IN_FLAG) != 8'h00;
    // endpoint zero is bidirectional at address zero, both directions [R1] [R2]
    // endpoints 1..3: in at 0x80+n, out at n [R3]
    assign ep_hit = ((ep_addr & ~(`UTC_EP_IN_FLAG | `UTC_EP_NUM_MASK))
                     == 8'h00) && (num <= `UTC_EP_LAST);
    // pipe 0 serves ep0; pipes 1..6 are out/in pairs of eps 1..3 [R1]
    assign ep_pipe = (num == 4'h0) ? 3'h0 :
                     {num[1:0], 1'b0} - {2'h0, ~dir_in};
endmodule // utc_ep_decode

// ==== design/utc_transceiver_ctrl.v ====
`timescale 1ns/10ps
//
// Overview of operation
// R1: eight pipes; endpoint zero bidirectional at zero
// R2: endpoint zero always bidirectional
// R3: endpoints 1-3: IN 0x80+n, OUT n
// R4: speed one: full speed, pull-up on D+
// R5: speed zero: low speed, pull-up on D-
// R6: pull-up only while VBUS present
// R7: pull-up enable clear detaches device
// R8: phy enable clear: transceiver off, suspended
// R9: software starts USB clock before enable
// R10: low five bits: test and line status
// R11: peripheral function only, never host
// R12: diff receive bit follows D+/D- when enabled
// R13: status bits show D+ and D- levels
// R14: writes to status bits ignored
module utc_transceiver_ctrl (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // special function register port
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire [7:0] sfr_wdata,
    output reg  [7:0] sfr_rdata,
    // endpoint lookup
    input  wire [7:0] ep_addr,
    output reg        ep_hit,
    output reg  [2:0] ep_pipe,
    // cable side
    input  wire       vbus_present,
    input  wire       dplus_in,
    input  wire       dminus_in,
    input  wire       diff_rx_in,
    output reg        dplus_out,
    output reg        dminus_out,
    output reg        line_oe,
    output reg        pullup_dplus,
    output reg        pullup_dminus,
    output reg        phy_suspend,
    output reg        full_speed
);
`include "utc_regs.vh"
    // states of the line test driver, one-hot
    localparam ST_IDLE  = 4'b0001;
    localparam ST_D1    = 4'b0010;
    localparam ST_D0    = 4'b0100;
    localparam ST_SE0   = 4'b1000;
    localparam [7:0] RESET_WORD = `UTC_RESET_VALUE;
    reg  [4:0] ctrl_hi;
    reg  [2:0] line_stat;
    reg  [3:0] test_state;
    reg  [3:0] next_test_state;
    reg  [4:0] next_ctrl_hi;
    reg  [2:0] next_line_stat;
    reg  [7:0] next_sfr_rdata;
    reg        next_dplus_out;
    reg        next_dminus_out;
    reg        next_line_oe;
    reg        next_pullup_dplus;
    reg        next_pullup_dminus;
    reg        next_phy_suspend;
    reg        next_full_speed;
    wire [4:0] wr_field;
    wire       pullup_enable;
    wire       phy_enable;
    wire       speed_full;
    wire [1:0] test_sel;
    wire       dec_hit;
    wire [2:0] dec_pipe;
    wire       pullup_on;

    function sel_hit;
        input [7:0] a;
        begin
            sel_hit = (a == `UTC_SFR_ADDR);
        end
    endfunction

    assign pullup_enable = ctrl_hi[`UTC_BIT_PULLUP_EN - `UTC_BIT_TEST_LO];
    assign phy_enable    = ctrl_hi[`UTC_BIT_PHY_EN - `UTC_BIT_TEST_LO];
    assign speed_full    = ctrl_hi[`UTC_BIT_SPEED - `UTC_BIT_TEST_LO];
    assign test_sel      = ctrl_hi[`UTC_BIT_TEST_HI - `UTC_BIT_TEST_LO:0];
    assign wr_field      = sfr_wdata[`UTC_BIT_PULLUP_EN:`UTC_BIT_TEST_LO];
    // pull-up needs both the enable and VBUS [R6] [R7]
    assign pullup_on     = pullup_enable & vbus_present;

    // only the writable upper field is stored [R14]
    always @* begin
        next_ctrl_hi = ctrl_hi;
        if (sfr_wr && sel_hit(sfr_addr)) begin
            next_ctrl_hi = wr_field; // [R10]
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_hi <= RESET_WORD[`UTC_BIT_PULLUP_EN:`UTC_BIT_TEST_LO];
        end else begin
            ctrl_hi <= next_ctrl_hi;
        end
    end

    // the diff bit reads zero while the phy is off [R12]
    always @* begin
        next_line_stat                   = 3'h0;
        next_line_stat[`UTC_BIT_DIFF_RX] = diff_rx_in & phy_enable; // [R12]
        next_line_stat[`UTC_BIT_DPLUS]   = dplus_in;                // [R13]
        next_line_stat[`UTC_BIT_DMINUS]  = dminus_in;               // [R13]
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            line_stat <= RESET_WORD[`UTC_BIT_DIFF_RX:`UTC_BIT_DMINUS];
        end else begin
            line_stat <= next_line_stat;
        end
    end

    always @* begin
        next_test_state = ST_IDLE;
        if (phy_enable) begin
            case (test_sel)
                `UTC_TEST_DIFF_ONE:  next_test_state = ST_D1;
                `UTC_TEST_DIFF_ZERO: next_test_state = ST_D0;
                `UTC_TEST_SE_ZERO:   next_test_state = ST_SE0;
                default:             next_test_state = ST_IDLE;
            endcase
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            test_state <= ST_IDLE;
        end else begin
            test_state <= next_test_state; // [R10]
        end
    end

    // test driver forces the line; the sie owns it otherwise
    always @* begin
        next_dplus_out  = 1'b0;
        next_dminus_out = 1'b0;
        next_line_oe    = 1'b0;
        case (test_state)
            ST_D1: begin
                next_dplus_out = 1'b1;
                next_line_oe   = 1'b1;
            end
            ST_D0: begin
                next_dminus_out = 1'b1;
                next_line_oe    = 1'b1;
            end
            ST_SE0: begin
                next_line_oe = 1'b1;
            end
            default: begin
                next_line_oe = 1'b0;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dplus_out  <= 1'b0;
            dminus_out <= 1'b0;
            line_oe    <= 1'b0;
        end else begin
            dplus_out  <= next_dplus_out;  // [R10]
            dminus_out <= next_dminus_out; // [R10]
            line_oe    <= next_line_oe;    // [R10]
        end
    end

    // function only: pull-up signals attach, host pull-downs never exist [R11]
    always @* begin
        next_pullup_dplus  = pullup_on & speed_full;  // [R4]
        next_pullup_dminus = pullup_on & ~speed_full; // [R5]
        next_phy_suspend   = ~phy_enable;             // [R8]
        next_full_speed    = speed_full;              // [R4] [R5]
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pullup_dplus  <= 1'b0;
            pullup_dminus <= 1'b0;
            phy_suspend   <= ~RESET_WORD[`UTC_BIT_PHY_EN];
            full_speed    <= RESET_WORD[`UTC_BIT_SPEED];
        end else begin
            pullup_dplus  <= next_pullup_dplus;
            pullup_dminus <= next_pullup_dminus;
            phy_suspend   <= next_phy_suspend;
            full_speed    <= next_full_speed;
        end
    end

    // other addresses read as zero
    always @* begin
        next_sfr_rdata = 8'h00;
        if (sel_hit(sfr_addr)) begin
            next_sfr_rdata = {ctrl_hi, line_stat}; // [R10]
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= next_sfr_rdata;
        end
    end

    utc_ep_decode u_ep_decode (
        .ep_addr (ep_addr),
        .ep_hit  (dec_hit),
        .ep_pipe (dec_pipe)
    );

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ep_hit  <= 1'b0;
            ep_pipe <= 3'h0;
        end else begin
            ep_hit  <= dec_hit;  // [R1] [R3]
            ep_pipe <= dec_pipe; // [R2]
        end
    end
endmodule // utc_transceiver_ctrl

// ==== testbench/utc_host_model.sv ====
`timescale 1ns/10ps
// host end of the cable: holds whatever bus state the bench asks for
module utc_host_model (
    // requested bus state {d+, d-} and vbus
    input  wire logic [1:0] line_st,
    input  wire logic       vbus_on,
    // cable levels seen by the block
    output wire logic       vbus_present,
    output wire logic       dplus_in,
    output wire logic       dminus_in,
    output wire logic       diff_rx_in
);
    assign vbus_present = vbus_on;
    assign {dplus_in, dminus_in} = line_st;
    // se0 reads as differential zero, as a real receiver may
    assign diff_rx_in = line_st == 2'b10;
endmodule // utc_host_model

// ==== testbench/utc_transceiver_ctrl_assertions.sv ====
`timescale 1ns/10ps
module utc_transceiver_ctrl_assertions (
    // clock, reset and register port
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // endpoint lookup and cable side
    input wire logic [7:0] ep_addr,
    input wire logic       ep_hit,
    input wire logic [2:0] ep_pipe,
    input wire logic       vbus_present,
    input wire logic       dplus_in,
    input wire logic       dminus_in,
    input wire logic       pullup_dplus,
    input wire logic       pullup_dminus,
    input wire logic       phy_suspend,
    input wire logic       full_speed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr;
        sfr_wr && sfr_addr == 8'hD7;
    endsequence
    // three quiet cycles cover input flop plus read flop
    sequence s_quiet;
        ($stable(dplus_in) && $stable(dminus_in) && sfr_addr == 8'hD7) [*3];
    endsequence
    ep_zero_a: assert property (
        ep_addr == 8'h00 |=> ep_hit && ep_pipe == 3'h0)
        else $error("endpoint zero not decoded");
    ep_pair_a: assert property (
        ep_addr[6:2] == 5'h0 && ep_addr[1:0] != 2'h0 |=> ep_hit &&
        ep_pipe == ($past(ep_addr[7]) ? {$past(ep_addr[1:0]), 1'b0} :
                    {$past(ep_addr[1:0]), 1'b0} - 3'h1))
        else $error("endpoint pipe wrong");
    pu_full_a: assert property (pullup_dplus |-> full_speed)
        else $error("d+ pull-up at low speed");
    pu_low_a: assert property (pullup_dminus |-> !full_speed)
        else $error("d- pull-up at full speed");
    pu_vbus_a: assert property (
        !vbus_present [*3] |-> !pullup_dplus && !pullup_dminus)
        else $error("pull-up without vbus");
    pu_off_a: assert property (
        s_wr ##0 !sfr_wdata[7] |-> ##2 !pullup_dplus && !pullup_dminus)
        else $error("pull-up left on");
    phy_off_a: assert property (
        s_wr |-> ##2 phy_suspend == !$past(sfr_wdata[6], 2))
        else $error("suspend wrong");
    status_a: assert property (
        s_quiet |-> sfr_rdata[1:0] == {dplus_in, dminus_in})
        else $error("line status wrong");
endmodule // utc_transceiver_ctrl_assertions

// ==== testbench/utc_transceiver_ctrl_tb_top.sv ====
`timescale 1ns/10ps
module utc_transceiver_ctrl_tb_top;
    logic       clk, rst, sfr_wr, vbus_on, vbus_present, diff_rx_in;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ep_addr;
    logic [1:0] line_st;
    logic [2:0] ep_pipe;
    logic       dplus_in, dminus_in, ep_hit, dplus_out, dminus_out;
    logic       line_oe, pullup_dplus, pullup_dminus, phy_suspend, full_speed;
    int         n_mismatch, n_tests, i;
    utc_host_model u_utc_host_model (
        .line_st      (line_st),
        .vbus_on      (vbus_on),
        .vbus_present (vbus_present),
        .dplus_in     (dplus_in),
        .dminus_in    (dminus_in),
        .diff_rx_in   (diff_rx_in)
    );
    utc_transceiver_ctrl u_utc_transceiver_ctrl (
        .clk           (clk),
        .rst           (rst),
        .sfr_addr      (sfr_addr),
        .sfr_wr        (sfr_wr),
        .sfr_wdata     (sfr_wdata),
        .sfr_rdata     (sfr_rdata),
        .ep_addr       (ep_addr),
        .ep_hit        (ep_hit),
        .ep_pipe       (ep_pipe),
        .vbus_present  (vbus_present),
        .dplus_in      (dplus_in),
        .dminus_in     (dminus_in),
        .diff_rx_in    (diff_rx_in),
        .dplus_out     (dplus_out),
        .dminus_out    (dminus_out),
        .line_oe       (line_oe),
        .pullup_dplus  (pullup_dplus),
        .pullup_dminus (pullup_dminus),
        .phy_suspend   (phy_suspend),
        .full_speed    (full_speed)
    );
    task automatic chk(input string s, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    // outputs settle within three edges of the write edge
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk);
        sfr_addr <= a;
        repeat (2) @(posedge clk);
        #1;
        chk("rdata", e, sfr_rdata);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        n_mismatch++;
        summarize;
    end
    initial begin
        {sfr_wr, vbus_on, sfr_addr, sfr_wdata, ep_addr, line_st} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(8'hD7, 8'h00);
        chk("suspend", 8'h01, {7'h0, phy_suspend});
        $display("test reset done");
        @(posedge clk);
        line_st <= 2'b10;
        vbus_on <= 1'b1;
        // clock runs from time zero, so enabling the phy is safe
        wr(8'hD7, 8'hFF);
        rd(8'hD7, 8'hFE);
        $display("test write done");
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            vbus_on <= i[0];
            wr(8'hD7, {2'b11, i[1], 5'h0});
            chk("pull", {6'h0, i[0] & i[1], i[0] & ~i[1]},
                {6'h0, pullup_dplus, pullup_dminus});
            chk("speed", {7'h0, i[1]}, {7'h0, full_speed});
        end
        wr(8'hD7, 8'h60);
        chk("detach", 8'h0, {pullup_dplus, pullup_dminus});
        wr(8'hD7, 8'h80);
        chk("suspend", 8'h01, {7'h0, phy_suspend});
        rd(8'hD7, 8'h82);
        $display("test pullup done");
        for (i = 0; i < 4; i++) begin
            wr(8'hD7, {3'b010, i[1:0], 3'h0});
            chk("drive", {5'h0, i != 0, i == 1, i == 2},
                {5'h0, line_oe, line_oe & dplus_out,
                 line_oe & dminus_out});
        end
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            line_st <= i[1:0];
            rd(8'hD7, {3'b010, 2'b11, i == 2, i[1:0]});
        end
        wr(8'hD6, 8'hBF);
        rd(8'hD6, 8'h00);
        rd(8'hD7, 8'h5B);
        $display("test phy done");
        for (i = 0; i < 10; i++) begin
            @(posedge clk);
            ep_addr <= {i[0], 4'h0, i[3:1]};
            repeat (2) @(posedge clk);
            #1;
            chk("ep", i < 8 ? {4'h1, i == 0 ? 3'h0 : 3'(i - 1)} : 8'h0,
                {4'h0, ep_hit, ep_hit ? ep_pipe : 3'h0});
        end
        $display("test endpoint done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("rst drive", 8'h0, {pullup_dplus, pullup_dminus, line_oe});
        chk("rst suspend", 8'h01, {7'h0, phy_suspend});
        rd(8'hD7, 8'h03);
        $display("test mid-run reset done");
        summarize;
    end
endmodule // utc_transceiver_ctrl_tb_top
bind utc_transceiver_ctrl utc_transceiver_ctrl_assertions u_chk (
    .clk           (clk),
    .rst           (rst),
    .sfr_addr      (sfr_addr),
    .sfr_wr        (sfr_wr),
    .sfr_wdata     (sfr_wdata),
    .sfr_rdata     (sfr_rdata),
    .ep_addr       (ep_addr),
    .ep_hit        (ep_hit),
    .ep_pipe       (ep_pipe),
    .vbus_present  (vbus_present),
    .dplus_in      (dplus_in),
    .dminus_in     (dminus_in),
    .pullup_dplus  (pullup_dplus),
    .pullup_dminus (pullup_dminus),
    .phy_suspend   (phy_suspend),
    .full_speed    (full_speed)
);
